// file: shared/meter_pkg.sv
// Constants for the meter command and status core.
// Assumes a host parser that hands over decoded commands one at a time.
package meter_pkg;
  // ****************************************
  // Register layout
  // ****************************************
  localparam int DEV_STATUS_W = 16;
  localparam int SENSOR_ERR_BIT = 3;
  localparam int OPC_EVENT_BIT = 0;
  localparam logic [7:0] OPC_ASCII = 8'h31;
  // ****************************************
  // Save slots and calculation blocks
  // ****************************************
  localparam int SLOT_COUNT = 10;
  localparam logic [3:0] SLOT_MIN = 4'h1;
  localparam logic [3:0] SLOT_MAX = 4'hA;
  localparam int CALC_BLOCKS = 4;
  // ****************************************
  // Configuration fields and reset values
  // ****************************************
  localparam int EXP_W = 16;
  localparam int RES_W = 3;
  localparam int SRC_W = 2;
  localparam int FN_W = 2;
  localparam int CFG_W = EXP_W + RES_W + SRC_W + FN_W;
  localparam logic [EXP_W-1:0] EXP_RESET = 16'h0014;
  localparam logic [RES_W-1:0] RES_RESET = 3'h3;
  localparam logic [SRC_W-1:0] SRC_RESET = 2'h1;
  localparam logic [FN_W-1:0] FN_SINGLE = 2'h0;
  localparam logic [FN_W-1:0] FN_DIFF = 2'h1;
  localparam logic [FN_W-1:0] FN_RATIO = 2'h2;
  // ****************************************
  // Commands
  // ****************************************
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_CLS = 4'h1,
    CMD_ESE = 4'h2,
    CMD_OPCQ = 4'h3,
    CMD_OPC = 4'h4,
    CMD_STBQ = 4'h5,
    CMD_SAV = 4'h6,
    CMD_RCL = 4'h7,
    CMD_CONF = 4'h8,
    CMD_INIT = 4'h9,
    CMD_FETCH = 4'hA,
    CMD_READ = 4'hB,
    CMD_MEAS = 4'hC,
    CMD_ABORT = 4'hD
  } cmd_t;
  // Optional argument presence flags
  localparam int ARG_EXP = 0;
  localparam int ARG_RES = 1;
  localparam int ARG_SRC = 2;
endpackage : meter_pkg

// file: rtl/meter_step_seq.sv
// Step sequencer splitting compound measurement commands.
// Assumes the caller holds start for one cycle and accepts steps in order.
`timescale 1ns/1ps
module meter_step_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic flush,
  input wire meter_pkg::cmd_t cmd,
  input wire logic stepDone,
  // Step output
  output logic stepValid,
  output meter_pkg::cmd_t step,
  output logic busy
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ABORT = 3'b001,
    S_CONF = 3'b010,
    S_INIT = 3'b011,
    S_FETCH = 3'b100
  } seq_t;
  typedef struct packed {
    seq_t st;
    logic withConf;
  } state_t;
  state_t q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (flush) begin
      q_nxt.st = S_IDLE;
    end else begin
      case (q_r.st)
        S_IDLE: begin
          if (start && cmd == meter_pkg::CMD_MEAS) begin
            q_nxt.st = S_ABORT; // R12
            q_nxt.withConf = 1'b1;
          end else if (start && cmd == meter_pkg::CMD_READ) begin
            q_nxt.st = S_ABORT; // R13
            q_nxt.withConf = 1'b0;
          end
        end
        S_ABORT: begin
          if (stepDone) begin
            q_nxt.st = q_r.withConf ? S_CONF : S_INIT; // R12 R13
          end
        end
        S_CONF: begin
          if (stepDone) begin
            q_nxt.st = S_INIT;
          end
        end
        S_INIT: begin
          if (stepDone) begin
            q_nxt.st = S_FETCH;
          end
        end
        S_FETCH: begin
          if (stepDone) begin
            q_nxt.st = S_IDLE;
          end
        end
        default: begin
          q_nxt.st = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_r <= '{st: S_IDLE, withConf: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  always_comb begin
    stepValid = (q_r.st != S_IDLE);
    busy = (q_r.st != S_IDLE);
    case (q_r.st)
      S_ABORT: step = meter_pkg::CMD_ABORT;
      S_CONF: step = meter_pkg::CMD_CONF;
      S_INIT: step = meter_pkg::CMD_INIT;
      S_FETCH: step = meter_pkg::CMD_FETCH;
      default: step = meter_pkg::CMD_NONE;
    endcase
  end
endmodule : meter_step_seq

// file: rtl/meter_command_status_core.sv
// Command and status core of a remotely programmed power meter.
// Assumes decoded commands arrive with a valid/ready handshake.
//
// Overview of operation
// (R1) Device status bit 3 tracks sensor memory failure
// (R2) Other device status bits zero, bit 15 zero
// (R3) Completion query queues ASCII 1 when idle
// (R4) Completion command sets event bit 0 when idle
// (R5) Status byte query clears nothing
// (R6) Host syncs: clear, cls, enable, query, poll
// (R7) Ten stored configurations can be saved, restored
// (R8) Save excludes errors, addresses, offsets, calibration
// (R9) Slot numbers limited to one through ten
// (R10) Device clear keeps status, errors, configuration
// (R11) Device clear aborts, idles, flushes, readies
// (R12) Measure runs abort, configure, read in order
// (R13) Read runs abort, initiate, fetch in order
// (R14) Configure updates settings, never starts measurement
// (R15) Fetch returns last acquired result, no acquisition
// (R16) Numeric suffix selects calculation block
// (R17) Optional arguments: level, resolution, source list
// (R18) Difference/ratio resolution applies to both channels
// (R19) Source list selects channel and operand pair
// (R20) Reset defaults: resolution 3, +20 dBm, single
// (R21) Commands handled strictly in arrival order; completion reports wait while later commands are taken and run first
`timescale 1ns/1ps
module meter_command_status_core #(
  parameter int SLOTS = meter_pkg::SLOT_COUNT,
  parameter int BLOCKS = meter_pkg::CALC_BLOCKS,
  parameter int RESULT_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Command port
  input wire logic cmdValid,
  input wire meter_pkg::cmd_t cmdCode,
  input wire logic [1:0] cmdBlock,
  input wire logic [3:0] cmdSlot,
  input wire logic [2:0] cmdArgMask,
  input wire logic [meter_pkg::EXP_W-1:0] cmdExpected,
  input wire logic [meter_pkg::RES_W-1:0] cmdResolution,
  input wire logic [meter_pkg::SRC_W-1:0] cmdSource,
  input wire logic [meter_pkg::FN_W-1:0] cmdFunction,
  input wire logic [7:0] cmdEseValue,
  output logic cmdReady,
  // Device clear
  input wire logic devClear,
  // Sensor and acquisition
  input wire logic sensorMemFail,
  input wire logic acqDone,
  input wire logic [RESULT_W-1:0] acqResult,
  output logic acqStart,
  output logic acqAbort,
  output logic [meter_pkg::CFG_W-1:0] acqConfig,
  // Responses
  output logic outValid,
  output logic [RESULT_W-1:0] outData,
  output logic outFlush,
  output logic [meter_pkg::DEV_STATUS_W-1:0] devStatus,
  output logic [7:0] eventStatus,
  output logic [7:0] eventEnable,
  output logic slotError
);
  // ****************************************
  // Configuration record helpers
  // ****************************************
  typedef logic [meter_pkg::CFG_W-1:0] cfg_t;

  function automatic cfg_t defaultCfg();
    defaultCfg = {meter_pkg::FN_SINGLE, meter_pkg::SRC_RESET,
      meter_pkg::RES_RESET, meter_pkg::EXP_RESET}; // R20
  endfunction : defaultCfg

  function automatic cfg_t applyArgs(input cfg_t old, input logic [2:0] m,
      input logic [meter_pkg::EXP_W-1:0] e,
      input logic [meter_pkg::RES_W-1:0] r,
      input logic [meter_pkg::SRC_W-1:0] s,
      input logic [meter_pkg::FN_W-1:0] f);
    cfg_t c;
    c = old;
    c[meter_pkg::CFG_W-1 -: meter_pkg::FN_W] = f;
    if (m[meter_pkg::ARG_EXP]) begin
      c[meter_pkg::EXP_W-1:0] = e; // R17
    end
    if (m[meter_pkg::ARG_RES]) begin
      // One resolution for both operands of diff or ratio
      c[meter_pkg::EXP_W +: meter_pkg::RES_W] = r; // R18
    end
    if (m[meter_pkg::ARG_SRC]) begin
      c[meter_pkg::EXP_W+meter_pkg::RES_W +: meter_pkg::SRC_W] = s; // R19
    end
    applyArgs = c;
  endfunction : applyArgs

  function automatic logic slotOk(input logic [3:0] s);
    slotOk = (s >= meter_pkg::SLOT_MIN) && (s <= meter_pkg::SLOT_MAX); // R9
  endfunction : slotOk

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [BLOCKS-1:0][meter_pkg::CFG_W-1:0] cfg;
    logic [SLOTS-1:0][BLOCKS-1:0][meter_pkg::CFG_W-1:0] saved;
    logic [BLOCKS-1:0][RESULT_W-1:0] result;
    logic [1:0] blk;
    logic [2:0] argMask;
    logic [meter_pkg::EXP_W-1:0] exp;
    logic [meter_pkg::RES_W-1:0] res;
    logic [meter_pkg::SRC_W-1:0] src;
    logic [meter_pkg::FN_W-1:0] fn;
    logic acqBusy;
    logic opcqPend;
    logic opcPend;
    logic cmdReady;
    logic acqStart;
    logic acqAbort;
    logic [meter_pkg::CFG_W-1:0] acqConfig;
    logic outValid;
    logic [RESULT_W-1:0] outData;
    logic outFlush;
    logic [meter_pkg::DEV_STATUS_W-1:0] devStatus;
    logic [7:0] esr;
    logic [7:0] ese;
    logic slotError;
  } state_t;
  state_t q_r, q_nxt;

  // ****************************************
  // Step sequencer
  // ****************************************
  logic seqStart;
  logic seqValid;
  logic seqBusy;
  logic stepDone;
  meter_pkg::cmd_t seqStep;
  meter_pkg::cmd_t curCmd;
  logic busy;
  logic take;

  assign busy = seqBusy || q_r.acqBusy;
  // In-order: next command waits for compound and acquisition
  assign take = cmdValid && q_r.cmdReady && !devClear; // R21
  assign seqStart = take &&
    (cmdCode == meter_pkg::CMD_MEAS || cmdCode == meter_pkg::CMD_READ);
  assign curCmd = seqValid ? seqStep : (take ? cmdCode : meter_pkg::CMD_NONE);

  meter_step_seq u_seq (
    .clk(clk),
    .nrst(nrst),
    .start(seqStart),
    .flush(devClear),
    .cmd(cmdCode),
    .stepDone(stepDone),
    .stepValid(seqValid),
    .step(seqStep),
    .busy(seqBusy)
  );

  // INIT step completes on acquisition done, others at once
  assign stepDone = seqValid && (seqStep != meter_pkg::CMD_INIT ||
    (q_r.acqBusy && acqDone)); // R13

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [1:0] b;
    b = take ? cmdBlock : q_r.blk; // R16
    q_nxt = q_r;
    q_nxt.acqStart = 1'b0;
    q_nxt.acqAbort = 1'b0;
    q_nxt.outValid = 1'b0;
    q_nxt.outFlush = 1'b0;
    q_nxt.slotError = 1'b0;
    if (take) begin
      q_nxt.blk = cmdBlock;
      q_nxt.argMask = cmdArgMask;
      q_nxt.exp = cmdExpected;
      q_nxt.res = cmdResolution;
      q_nxt.src = cmdSource;
      q_nxt.fn = cmdFunction;
    end
    if (q_r.acqBusy && acqDone) begin
      q_nxt.acqBusy = 1'b0;
      q_nxt.result[q_r.blk] = acqResult; // R15
    end
    case (curCmd)
      meter_pkg::CMD_CLS: begin
        q_nxt.esr = 8'h00;
      end
      meter_pkg::CMD_ESE: begin
        q_nxt.ese = cmdEseValue;
      end
      meter_pkg::CMD_OPCQ: begin
        q_nxt.opcqPend = 1'b1;
      end
      meter_pkg::CMD_OPC: begin
        q_nxt.opcPend = 1'b1;
      end
      meter_pkg::CMD_STBQ: begin
        // Read-only: no status bit is touched
        q_nxt.outValid = 1'b1; // R5
        q_nxt.outData = RESULT_W'({q_r.esr != 8'h00, q_r.outValid});
      end
      meter_pkg::CMD_SAV: begin
        if (slotOk(cmdSlot)) begin
          q_nxt.saved[cmdSlot - 4'h1] = q_r.cfg; // R7 R8
        end else begin
          q_nxt.slotError = 1'b1; // R9
        end
      end
      meter_pkg::CMD_RCL: begin
        if (slotOk(cmdSlot)) begin
          q_nxt.cfg = q_r.saved[cmdSlot - 4'h1]; // R7 R8
        end else begin
          q_nxt.slotError = 1'b1; // R9
        end
      end
      meter_pkg::CMD_CONF: begin
        // Settings only; acquisition is not started
        q_nxt.cfg[b] = applyArgs(q_r.cfg[b],
          seqValid ? q_r.argMask : cmdArgMask,
          seqValid ? q_r.exp : cmdExpected,
          seqValid ? q_r.res : cmdResolution,
          seqValid ? q_r.src : cmdSource,
          seqValid ? q_r.fn : cmdFunction); // R14
      end
      meter_pkg::CMD_INIT: begin
        if (!q_r.acqBusy && !q_r.acqStart) begin
          q_nxt.acqStart = 1'b1;
          q_nxt.acqBusy = 1'b1;
          q_nxt.acqConfig = q_r.cfg[b];
        end
      end
      meter_pkg::CMD_FETCH: begin
        q_nxt.outValid = 1'b1; // R15
        q_nxt.outData = q_r.result[b];
      end
      meter_pkg::CMD_ABORT: begin
        q_nxt.acqAbort = 1'b1;
        q_nxt.acqBusy = 1'b0;
      end
      default: begin
      end
    endcase
    // Completion reporting once nothing is pending
    if (q_r.opcqPend && !busy && !take) begin
      q_nxt.opcqPend = 1'b0;
      q_nxt.outValid = 1'b1; // R3
      q_nxt.outData = RESULT_W'(meter_pkg::OPC_ASCII);
    end
    if (q_r.opcPend && !busy && !take) begin
      q_nxt.opcPend = 1'b0;
      q_nxt.esr[meter_pkg::OPC_EVENT_BIT] = 1'b1; // R4
    end
    q_nxt.devStatus = '0; // R2
    q_nxt.devStatus[meter_pkg::SENSOR_ERR_BIT] = sensorMemFail; // R1
    // Device clear: status, errors and configuration kept
    if (devClear) begin // R10
      q_nxt.acqAbort = q_r.acqBusy; // R11
      q_nxt.acqBusy = 1'b0; // R11
      q_nxt.acqStart = 1'b0;
      q_nxt.opcqPend = 1'b0;
      q_nxt.opcPend = 1'b0;
      q_nxt.outValid = 1'b0;
      q_nxt.outFlush = 1'b1; // R11
    end
    q_nxt.cmdReady = !devClear && !seqStart &&
      !(seqBusy && !(seqValid && seqStep == meter_pkg::CMD_FETCH &&
      stepDone)) && !(q_nxt.acqBusy && !seqBusy) ; // R21
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_r <= '0;
      for (int i = 0; i < BLOCKS; i++) begin
        q_r.cfg[i] <= defaultCfg(); // R20
      end
      q_r.cmdReady <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cmdReady = q_r.cmdReady;
  assign acqStart = q_r.acqStart;
  assign acqAbort = q_r.acqAbort;
  assign acqConfig = q_r.acqConfig;
  assign outValid = q_r.outValid;
  assign outData = q_r.outData;
  assign outFlush = q_r.outFlush;
  assign devStatus = q_r.devStatus;
  assign eventStatus = q_r.esr;
  assign eventEnable = q_r.ese;
  assign slotError = q_r.slotError;
endmodule : meter_command_status_core

// file: testbench/meter_core_monitor.sv
// Checker for the meter command and status core.
// Bound to the core; sees only its ports.
`timescale 1ns/1ps
module meter_core_monitor #(
  parameter int RESULT_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Command side
  input wire logic cmdValid,
  input wire meter_pkg::cmd_t cmdCode,
  input wire logic [3:0] cmdSlot,
  input wire logic cmdReady,
  input wire logic devClear,
  input wire logic sensorMemFail,
  // Outputs
  input wire logic acqStart,
  input wire logic outValid,
  input wire logic [RESULT_W-1:0] outData,
  input wire logic outFlush,
  input wire logic [meter_pkg::DEV_STATUS_W-1:0] devStatus,
  input wire logic [7:0] eventStatus,
  input wire logic [7:0] eventEnable,
  input wire logic slotError
);
  // ****************************************
  // Helpers
  // ****************************************
  logic take;
  logic badSlot;
  assign take = cmdValid && cmdReady && !devClear;
  assign badSlot = cmdSlot < meter_pkg::SLOT_MIN ||
    cmdSlot > meter_pkg::SLOT_MAX;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ****************************************
  // Assertions
  // ****************************************
  sensor_bit_a: assert property (
    devStatus[3] == $past(sensorMemFail)) else $error("sensor bit wrong");
  unused_bits_a: assert property (
    devStatus[15:4] == 12'h000 && devStatus[2:0] == 3'h0)
    else $error("unused status bit set");
  opc_query_a: assert property (
    take && cmdCode == meter_pkg::CMD_OPCQ |-> ##[1:50]
    (outValid && outData == RESULT_W'(meter_pkg::OPC_ASCII)))
    else $error("completion query not answered");
  opc_event_a: assert property (
    take && cmdCode == meter_pkg::CMD_OPC |-> ##[1:50] eventStatus[0])
    else $error("completion event missing");
  stb_keeps_a: assert property (
    take && cmdCode == meter_pkg::CMD_STBQ |=>
    eventStatus == $past(eventStatus)) else $error("status query cleared");
  clear_flush_a: assert property (
    $rose(devClear) |=> outFlush) else $error("no flush on clear");
  clear_keeps_a: assert property (
    devClear |=> $stable(eventEnable)) else $error("clear lost enable");
  clear_ready_a: assert property (
    $fell(devClear) |-> ##[0:4] cmdReady) else $error("not ready after clear");
  slot_range_a: assert property (
    take && cmdCode inside {meter_pkg::CMD_SAV, meter_pkg::CMD_RCL} &&
    badSlot |=> slotError) else $error("bad slot accepted");
  no_start_a: assert property (
    take && cmdCode inside {meter_pkg::CMD_CONF, meter_pkg::CMD_FETCH}
    |=> !acqStart [*3]) else $error("acquisition started");
  fetch_answer_a: assert property (
    take && cmdCode == meter_pkg::CMD_FETCH |-> ##[1:2] outValid)
    else $error("fetch not answered");
endmodule : meter_core_monitor

bind meter_command_status_core meter_core_monitor #(.RESULT_W(RESULT_W)) mon (
  .clk, .nrst, .cmdValid, .cmdCode, .cmdSlot, .cmdReady, .devClear,
  .sensorMemFail, .acqStart, .outValid, .outData, .outFlush, .devStatus,
  .eventStatus, .eventEnable, .slotError);

// file: testbench/meter_acq_model.sv
// Acquisition engine model answering start and abort pulses.
// Assumes one acquisition at a time; slow selects a long delay.
`timescale 1ns/1ps
module meter_acq_model #(
  parameter int RESULT_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic slow,
  input wire logic acqStart,
  input wire logic acqAbort,
  // Result
  output logic acqDone,
  output logic [RESULT_W-1:0] acqResult
);
  int cnt;
  logic [RESULT_W-1:0] val;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      val <= RESULT_W'(32'hA5000000);
      acqDone <= 1'h0;
      acqResult <= '0;
    end else begin
      acqDone <= cnt == 1;
      // Result is only valid with the done pulse
      acqResult <= (cnt == 1) ? val + 1 : ~acqResult;
      if (cnt == 1) val <= val + 1;
      if (acqAbort) cnt <= 0;
      else if (acqStart) cnt <= slow ? 40 : 3;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule : meter_acq_model

// file: testbench/meter_command_status_core_tb_top.sv
// Self-checking bench for the meter command and status core.
// Assumes the acquisition model in the same folder.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin failCount++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module meter_command_status_core_tb_top;
  typedef struct packed {
    meter_pkg::cmd_t code;
    logic [3:0] slot;
    logic err;
  } row_t;
  logic clk = 1'h0, nrst = 1'h0, cmdValid = 1'h0, devClear = 1'h0;
  logic sensorMemFail = 1'h0, slow = 1'h0, cmdReady, acqDone, acqStart;
  logic acqAbort, outValid, outFlush, slotError;
  meter_pkg::cmd_t cmdCode = meter_pkg::CMD_NONE;
  logic [1:0] cmdBlock = 2'h0, cmdSource = 2'h1, cmdFunction = 2'h0;
  logic [3:0] cmdSlot = 4'h1;
  logic [2:0] cmdArgMask = 3'h7, cmdResolution = 3'h3;
  logic [15:0] cmdExpected = 16'h0014, devStatus;
  logic [7:0] cmdEseValue = 8'h00, eventStatus, eventEnable, ev;
  logic [31:0] acqResult, outData, lastOut, lastAcq;
  logic [22:0] acqConfig, cfgSeen;
  int failCount = 0, nTests = 0, nOut = 0, nStart = 0, nAbort = 0;
  int nSlot = 0, k;
  row_t rows [6];
  always #2.5 clk = ~clk;
  meter_command_status_core uut (.clk(clk), .nrst(nrst),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdBlock(cmdBlock),
    .cmdSlot(cmdSlot), .cmdArgMask(cmdArgMask), .cmdExpected(cmdExpected),
    .cmdResolution(cmdResolution), .cmdSource(cmdSource),
    .cmdFunction(cmdFunction), .cmdEseValue(cmdEseValue),
    .cmdReady(cmdReady), .devClear(devClear), .sensorMemFail(sensorMemFail),
    .acqDone(acqDone), .acqResult(acqResult), .acqStart(acqStart),
    .acqAbort(acqAbort), .acqConfig(acqConfig), .outValid(outValid),
    .outData(outData), .outFlush(outFlush), .devStatus(devStatus),
    .eventStatus(eventStatus), .eventEnable(eventEnable),
    .slotError(slotError));
  meter_acq_model acq (.clk(clk), .nrst(nrst), .slow(slow),
    .acqStart(acqStart), .acqAbort(acqAbort), .acqDone(acqDone),
    .acqResult(acqResult));
  // ****************************************
  // Monitors and tasks
  // ****************************************
  always @(posedge clk) begin
    if (outValid) begin nOut++; lastOut = outData; end
    if (acqStart) begin nStart++; cfgSeen = acqConfig; end
    if (acqAbort) nAbort++;
    if (slotError) nSlot++;
    if (acqDone) lastAcq = acqResult;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic send(input meter_pkg::cmd_t c, input logic [1:0] b,
    input logic [3:0] s);
    int n;
    n = 0;
    cmdCode = c;
    cmdBlock = b;
    cmdSlot = s;
    cmdValid = 1'h1;
    while (cmdReady !== 1'h1 && n < 400) begin tick(1); n++; end
    if (cmdReady !== 1'h1) failCount++;
    tick(1);
    cmdValid = 1'h0;
  endtask : send
  task automatic waitc(ref int c, input int w);
    int n;
    n = 0;
    while (c == w && n < 400) begin tick(1); n++; end
    if (c == w) failCount++;
  endtask : waitc
  task endSim;
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : endSim
  initial begin
    #100000;
    failCount++;
    endSim;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rows = '{'{meter_pkg::CMD_SAV, 4'h0, 1'h1},
      '{meter_pkg::CMD_SAV, 4'h1, 1'h0}, '{meter_pkg::CMD_SAV, 4'hA, 1'h0},
      '{meter_pkg::CMD_SAV, 4'hB, 1'h1}, '{meter_pkg::CMD_RCL, 4'hF, 1'h1},
      '{meter_pkg::CMD_RCL, 4'hA, 1'h0}};
    tick(10);
    nrst = 1'h1;
    `CHK("devStatus", 16'h0000, devStatus)
    `CHK("cmdReady", 1'h1, cmdReady)
    k = nOut;
    send(meter_pkg::CMD_READ, 2'h0, 4'h1);
    waitc(nOut, k);
    `CHK("acqConfig", 23'h0B0014, cfgSeen)
    `CHK("outData", lastAcq, lastOut)
    $display("reset and read done");
    for (int i = 0; i < 6; i++) begin
      k = nSlot;
      send(rows[i].code, 2'h0, rows[i].slot);
      tick(3);
      `CHK("slotError", rows[i].err, nSlot != k)
    end
    $display("slot table done");
    sensorMemFail = 1'h1;
    tick(3);
    `CHK("devStatus", 16'h0008, devStatus)
    sensorMemFail = 1'h0;
    tick(3);
    `CHK("devStatus", 16'h0000, devStatus)
    $display("sensor error done");
    devClear = 1'h1;
    tick(1);
    devClear = 1'h0;
    tick(2);
    send(meter_pkg::CMD_CLS, 2'h0, 4'h1);
    cmdEseValue = 8'h01;
    send(meter_pkg::CMD_ESE, 2'h0, 4'h1);
    tick(2);
    `CHK("eventEnable", 8'h01, eventEnable)
    k = nOut;
    send(meter_pkg::CMD_OPCQ, 2'h0, 4'h1);
    waitc(nOut, k);
    `CHK("outData", 32'h00000031, lastOut)
    cmdExpected = 16'h0005;
    cmdResolution = 3'h2;
    send(meter_pkg::CMD_CONF, 2'h1, 4'h1);
    send(meter_pkg::CMD_OPC, 2'h0, 4'h1);
    tick(4);
    `CHK("opcBit", 1'h1, eventStatus[0])
    ev = eventStatus;
    send(meter_pkg::CMD_STBQ, 2'h0, 4'h1);
    tick(3);
    `CHK("eventStatus", ev, eventStatus)
    $display("sync sequence done");
    k = nStart;
    send(meter_pkg::CMD_INIT, 2'h1, 4'h1);
    waitc(nStart, k);
    `CHK("acqConfig", 23'h0A0005, cfgSeen)
    tick(8);
    k = nOut;
    send(meter_pkg::CMD_FETCH, 2'h1, 4'h1);
    waitc(nOut, k);
    `CHK("outData", lastAcq, lastOut)
    k = nStart;
    send(meter_pkg::CMD_FETCH, 2'h1, 4'h1);
    tick(4);
    `CHK("nStart", k, nStart)
    cmdFunction = meter_pkg::FN_RATIO;
    cmdResolution = 3'h4;
    cmdSource = 2'h2;
    cmdExpected = 16'h000A;
    k = nOut;
    send(meter_pkg::CMD_MEAS, 2'h2, 4'h1);
    waitc(nOut, k);
    `CHK("acqConfig", 23'h54000A, cfgSeen)
    `CHK("outData", lastAcq, lastOut)
    send(meter_pkg::CMD_SAV, 2'h0, 4'h3);
    cmdFunction = meter_pkg::FN_DIFF;
    cmdExpected = 16'h0007;
    send(meter_pkg::CMD_CONF, 2'h2, 4'h1);
    send(meter_pkg::CMD_RCL, 2'h0, 4'h3);
    k = nOut;
    send(meter_pkg::CMD_READ, 2'h2, 4'h1);
    waitc(nOut, k);
    `CHK("acqConfig", 23'h54000A, cfgSeen)
    $display("measurement and storage done");
    slow = 1'h1;
    k = nStart;
    send(meter_pkg::CMD_READ, 2'h1, 4'h1);
    waitc(nStart, k);
    k = nAbort;
    devClear = 1'h1;
    tick(1);
    devClear = 1'h0;
    tick(4);
    `CHK("aborted", 1'h1, nAbort != k)
    `CHK("cmdReady", 1'h1, cmdReady)
    `CHK("eventEnable", 8'h01, eventEnable)
    `CHK("opcBit", 1'h1, eventStatus[0])
    slow = 1'h0;
    k = nAbort;
    send(meter_pkg::CMD_ABORT, 2'h0, 4'h1);
    tick(3);
    `CHK("aborted", 1'h1, nAbort != k)
    $display("device clear done");
    cmdArgMask = 3'h1;
    cmdFunction = meter_pkg::FN_SINGLE;
    cmdExpected = 16'h0009;
    cmdResolution = 3'h1;
    cmdSource = 2'h3;
    send(meter_pkg::CMD_CONF, 2'h3, 4'h1);
    k = nStart;
    send(meter_pkg::CMD_INIT, 2'h3, 4'h1);
    waitc(nStart, k);
    `CHK("acqConfig", 23'h0B0009, cfgSeen)
    tick(8);
    $display("partial arguments done");
    endSim;
  end
endmodule : meter_command_status_core_tb_top
